// ==== design/gpm_top.sv ====
// Power-mode controller and signed current sampler of a battery gauge
`timescale 1ns/10ps
module gpm_top #(
	parameter int SLEEP_DELAY_CYC = gpm_pkg::SLEEP_DELAY_CYC,
	parameter int UV_DELAY_CYC    = gpm_pkg::UV_DELAY_CYC,
	parameter int SAMPLE_CYC      = gpm_pkg::SAMPLE_CYC,
	parameter int UPDATE_CYC      = gpm_pkg::UPDATE_CYC
) (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               bus_line,
	input  wire logic               sleep_allow_in,
	input  wire logic               undervoltage_sleep_allow_in,
	input  wire logic               cell_below_uv,
	input  wire logic signed [11:0] sense_pos_input,
	input  wire logic signed [11:0] sense_neg_input,
	input  wire logic               internal_resistor,
	input  wire logic [15:0]        gain_trim,
	output logic                    sleep_mode,
	output logic                    measure_enable,
	output logic signed [15:0]      current_reg,
	output logic                    current_update
);
	typedef struct packed {
		gpm_pkg::gpm_mode_t mode;
		logic               sleep_allow;
		logic               undervoltage_sleep_allow;
		logic               bus_prev;
		logic [31:0]        low_cnt;
		logic [31:0]        uv_cnt;
		logic [31:0]        samp_cnt;
		logic [31:0]        upd_cnt;
		logic               have_mean;
		logic signed [11:0] held_mean;
		logic signed [15:0] current_reg;
		logic               current_update;
		logic               add;
		logic               clear;
		logic signed [11:0] sample;
	} gpm_st_t;

	gpm_st_t st;
	gpm_st_t next_st;
	gpm_acc_if acc_bus ();

	if (SLEEP_DELAY_CYC < 1 || UV_DELAY_CYC < 1 || SAMPLE_CYC < 1) begin : g_bad_count
		$error("gpm_top: timing counts must be at least one cycle");
	end
	// A refresh must always have one whole averaging window behind it
	if (UPDATE_CYC < SAMPLE_CYC * gpm_pkg::AVG_N) begin : g_bad_period
		$error("gpm_top: update period shorter than one averaging window");
	end

	// Difference of two 12-bit inputs needs 13 bits before clamping back
	function automatic logic signed [11:0] gpm_sat12(input logic signed [12:0] v);
		if (v > 13'sh07FF) begin
			return 12'sh7FF;
		end else if (v < -13'sh0800) begin
			return -12'sh800;
		end
		return v[11:0];
	endfunction

	function automatic logic signed [15:0] gpm_sat16(input logic signed [31:0] v);
		if (v > 32'sh00007FFF) begin
			return 16'sh7FFF;
		end else if (v < -32'sh00008000) begin
			return -16'sh8000;
		end
		return v[15:0];
	endfunction

	logic signed [12:0] diff;
	logic signed [31:0] scaled;
	logic               bus_rise;

	assign diff = 13'(sense_pos_input) - 13'(sense_neg_input);
	assign bus_rise = bus_line && !st.bus_prev;

	always_comb begin
		next_st = st;
		next_st.bus_prev = bus_line;
		next_st.add = 1'b0;
		next_st.clear = 1'b0;
		next_st.current_update = 1'b0;
		next_st.sleep_allow = sleep_allow_in;
		next_st.undervoltage_sleep_allow = undervoltage_sleep_allow_in;
		scaled = '0;
		// Bus-low timer counts only one unbroken low interval
		if (bus_line) begin
			next_st.low_cnt = '0;
		end else if (st.low_cnt < 32'(SLEEP_DELAY_CYC)) begin
			next_st.low_cnt = st.low_cnt + 32'h1;
		end
		if (!cell_below_uv) begin
			next_st.uv_cnt = '0;
		end else if (st.uv_cnt < 32'(UV_DELAY_CYC)) begin
			next_st.uv_cnt = st.uv_cnt + 32'h1;
		end
		case (st.mode)
			gpm_pkg::GPM_ACTIVE: begin
				if (st.sleep_allow) begin
					if (st.low_cnt >= 32'(SLEEP_DELAY_CYC)) begin
						next_st.mode = gpm_pkg::GPM_SLEEP;
					end else if (st.undervoltage_sleep_allow
						&& st.uv_cnt >= 32'(UV_DELAY_CYC)) begin
						next_st.mode = gpm_pkg::GPM_SLEEP;
					end
				end
				// Sampling clock ticks at the sense sample rate
				if (st.samp_cnt >= 32'(SAMPLE_CYC - 1)) begin
					next_st.samp_cnt = '0;
					next_st.add = 1'b1;
					next_st.sample = gpm_sat12(diff);
				end else begin
					next_st.samp_cnt = st.samp_cnt + 32'h1;
				end
				if (acc_bus.done) begin
					next_st.held_mean = acc_bus.mean;
					next_st.have_mean = 1'b1;
				end
				// Register refresh on its own period from the last finished mean
				if (st.upd_cnt >= 32'(UPDATE_CYC - 1)) begin
					next_st.upd_cnt = '0;
					if (st.have_mean) begin
						if (internal_resistor) begin
							scaled = (32'(st.held_mean) * $signed({16'h0000, gain_trim}))
								>>> gpm_pkg::GAIN_SHIFT;
						end else begin
							scaled = 32'(st.held_mean);
						end
						next_st.current_reg = gpm_sat16(scaled);
						next_st.current_update = 1'b1;
					end
				end else begin
					next_st.upd_cnt = st.upd_cnt + 32'h1;
				end
			end
			gpm_pkg::GPM_SLEEP: begin
				// Partial averages are dropped so a wake starts a fresh window
				next_st.clear = 1'b1;
				next_st.samp_cnt = '0;
				next_st.upd_cnt = '0;
				next_st.have_mean = 1'b0;
				if (bus_rise && !cell_below_uv) begin
					next_st.mode = gpm_pkg::GPM_ACTIVE;
					next_st.low_cnt = '0;
					next_st.uv_cnt = '0;
				end
			end
			default: begin
				next_st.mode = gpm_pkg::GPM_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
			st.mode <= gpm_pkg::GPM_ACTIVE;
			st.sleep_allow <= gpm_pkg::SLEEP_ALLOW_RST;
			st.undervoltage_sleep_allow <= gpm_pkg::UV_SLEEP_ALLOW_RST;
			st.bus_prev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign acc_bus.clear = st.clear;
	assign acc_bus.add = st.add;
	assign acc_bus.sample = st.sample;

	gpm_avg #(
		.N_LOG2 (gpm_pkg::AVG_LOG2)
	) u_avg (
		.clk   (clk),
		.reset (reset),
		.bus   (acc_bus.acc)
	);

	assign sleep_mode = (st.mode == gpm_pkg::GPM_SLEEP);
	assign measure_enable = (st.mode == gpm_pkg::GPM_ACTIVE);
	assign current_reg = st.current_reg;
	assign current_update = st.current_update;
endmodule // gpm_top

// ==== design/gpm_pkg.sv ====
// Package of constants and types for the gauge power-mode and current sampler
package gpm_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int SENSE_W = 12;
	localparam int CUR_W = 16;
	localparam int AVG_N = 128;
	localparam int AVG_LOG2 = 7;
	localparam int SLEEP_DELAY_MS = 2200;
	localparam int UV_DELAY_MS = 100;
	localparam int UPDATE_MS = 88;
	localparam int SAMPLE_HZ = 1456;
	localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_MS * (CLK_HZ / 1000);
	localparam int UV_DELAY_CYC = UV_DELAY_MS * (CLK_HZ / 1000);
	localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
	localparam int UPDATE_CYC = UPDATE_MS * (CLK_HZ / 1000);
	localparam logic SLEEP_ALLOW_RST = 1'h0;
	localparam logic UV_SLEEP_ALLOW_RST = 1'h0;
	localparam logic [15:0] GAIN_UNITY = 16'h1000;
	localparam int GAIN_SHIFT = 12;
	typedef enum logic [0:0] {
		GPM_ACTIVE = 1'b0,
		GPM_SLEEP  = 1'b1
	} gpm_mode_t;
endpackage

// ==== design/gpm_acc_if.sv ====
// Interface between the sample controller and the averaging accumulator
`timescale 1ns/10ps
interface gpm_acc_if;
	logic              clear;
	logic              add;
	logic signed [11:0] sample;
	logic              done;
	logic signed [11:0] mean;
	modport ctrl (output clear, output add, output sample, input done, input mean);
	modport acc  (input clear, input add, input sample, output done, output mean);
endinterface

// ==== design/gpm_avg.sv ====
// Averaging accumulator: sums a fixed number of signed samples and yields the mean
`timescale 1ns/10ps
module gpm_avg #(
	parameter int N_LOG2 = gpm_pkg::AVG_LOG2
) (
	input  wire logic clk,
	input  wire logic reset,
	gpm_acc_if.acc    bus
);
	typedef struct packed {
		logic signed [19+N_LOG2-7:0] sum;
		logic [N_LOG2:0]             cnt;
		logic                        done;
		logic signed [11:0]          mean;
	} gpm_avg_st_t;
	gpm_avg_st_t st;
	gpm_avg_st_t next_st;
	if (N_LOG2 < 1 || N_LOG2 > 12) begin : g_bad_depth
		$error("gpm_avg: N_LOG2 out of range");
	end
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (bus.clear) begin
			next_st.sum = '0;
			next_st.cnt = '0;
		end else if (bus.add) begin
			if (st.cnt == (N_LOG2+1)'(1 << N_LOG2) - 1'b1) begin
				// Arithmetic shift keeps the sign of the mean
				next_st.mean = 12'((st.sum + (20+N_LOG2-7)'(bus.sample)) >>> N_LOG2);
				next_st.done = 1'b1;
				next_st.sum = '0;
				next_st.cnt = '0;
			end else begin
				next_st.sum = st.sum + (20+N_LOG2-7)'(bus.sample);
				next_st.cnt = st.cnt + 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign bus.done = st.done;
	assign bus.mean = st.mean;
endmodule // gpm_avg

// ==== testbench/gpm_props.sv ====
// Assertions and covers on the ports of the power-mode and current sampler
`timescale 1ns/10ps
module gpm_props #(
	parameter int SLEEP_DELAY_CYC = 50,
	parameter int UV_DELAY_CYC    = 20
) (
	input wire logic               clk,
	input wire logic               reset,
	input wire logic               bus_line,
	input wire logic               sleep_allow_in,
	input wire logic               undervoltage_sleep_allow_in,
	input wire logic               cell_below_uv,
	input wire logic               sleep_mode,
	input wire logic               measure_enable,
	input wire logic signed [15:0] current_reg,
	input wire logic               current_update
);
	logic [7:0] lo_cnt;
	logic [7:0] uv_cnt;
	// Saturating run lengths, so a very long low never wraps back to a small count
	always_ff @(posedge clk) begin
		lo_cnt <= (reset || bus_line) ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
		uv_cnt <= (reset || !cell_below_uv) ? 8'h00 : uv_cnt + {7'h00, uv_cnt != 8'hFF};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	reset_state_a: assert property ($past(reset) |-> !sleep_mode && current_reg == 16'h0000)
		else $error("wrong state after reset");
	measure_inv_a: assert property (measure_enable != sleep_mode)
		else $error("measure enable not inverse of sleep");
	allow_gate_a: assert property (!sleep_allow_in [*3] |-> !$rose(sleep_mode))
		else $error("sleep entered while not allowed");
	bus_sleep_a: assert property (lo_cnt == SLEEP_DELAY_CYC + 4 && $past(sleep_allow_in, 8)
		|-> sleep_mode) else $error("no sleep after long bus low");
	early_sleep_a: assert property ($rose(sleep_mode) |-> $past(lo_cnt, 2) >= SLEEP_DELAY_CYC - 3
		|| $past(uv_cnt, 2) >= UV_DELAY_CYC - 3) else $error("sleep entered too early");
	uv_sleep_a: assert property (uv_cnt == UV_DELAY_CYC + 4 && $past(sleep_allow_in, 8)
		&& $past(undervoltage_sleep_allow_in, 8) |-> sleep_mode) else $error("no undervoltage sleep");
	wake_rise_a: assert property (sleep_mode && $rose(bus_line) && !cell_below_uv |=> !sleep_mode)
		else $error("no wake on bus rise");
	stay_asleep_a: assert property (sleep_mode && !($rose(bus_line) && !cell_below_uv)
		|=> sleep_mode) else $error("left sleep without wake cause");
	sleep_quiet_a: assert property (sleep_mode && $past(sleep_mode) |-> !current_update)
		else $error("current update during sleep");
	reg_hold_a: assert property (!current_update |-> $stable(current_reg))
		else $error("current register changed without update");
	cover property ($rose(sleep_mode));
	cover property ($fell(sleep_mode));
	cover property (current_update && current_reg < 0);
endmodule // gpm_props

// ==== testbench/gpm_host.sv ====
// Behavioural host master driving the single-wire bus level
`timescale 1ns/10ps
module gpm_host (
	input  wire logic clk,
	output logic      bus_line
);
	// The host drives the line high itself whenever it is not holding it low
	initial bus_line = 1'h1;
	task automatic hold_low(input int n);
		@(posedge clk);
		bus_line <= 1'h0;
		repeat (n) @(posedge clk);
		bus_line <= 1'h1;
	endtask
endmodule // gpm_host

// ==== testbench/gpm_top_bench.sv ====
// Self-checking bench for the power-mode and current sampler
`timescale 1ns/10ps
module gpm_top_bench;
	logic               clk = 1'h0;
	logic               reset = 1'h1;
	logic               sleep_allow_in = 1'h0;
	logic               undervoltage_sleep_allow_in = 1'h0;
	logic               cell_below_uv = 1'h0;
	logic               internal_resistor;
	logic signed [11:0] sense_pos_input;
	logic signed [11:0] sense_neg_input;
	logic [15:0]        gain_trim;
	wire logic          bus_line;
	logic               sleep_mode;
	logic               measure_enable;
	logic signed [15:0] current_reg;
	logic               current_update;
	int                 miscompares = 0;
	int                 samples_checked = 0;
	always #5 clk = ~clk;
	gpm_host host (.clk, .bus_line);
	gpm_top #(.SLEEP_DELAY_CYC(50), .UV_DELAY_CYC(20), .SAMPLE_CYC(2), .UPDATE_CYC(256)) uut (
		.clk, .reset, .bus_line, .sleep_allow_in, .undervoltage_sleep_allow_in, .cell_below_uv,
		.sense_pos_input, .sense_neg_input, .internal_resistor, .gain_trim,
		.sleep_mode, .measure_enable, .current_reg, .current_update);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_defaults();
		@(negedge clk);
		chk({15'h0, sleep_mode}, 16'h0000);
		chk(current_reg, 16'h0000);
		host.hold_low(70);
		@(negedge clk);
		chk({15'h0, sleep_mode}, 16'h0000);
		$display("defaults done");
	endtask
	task automatic t_bus();
		@(posedge clk);
		sleep_allow_in <= 1'h1;
		cell_below_uv <= 1'h1;
		// One high cycle between two short lows must restart the count
		host.hold_low(30);
		host.hold_low(30);
		@(negedge clk);
		chk({15'h0, sleep_mode}, 16'h0000);
		host.hold_low(60);
		repeat (3) @(negedge clk);
		chk({14'h0, sleep_mode, measure_enable}, 16'h0002);
		@(posedge clk);
		cell_below_uv <= 1'h0;
		host.hold_low(2);
		repeat (3) @(negedge clk);
		chk({15'h0, sleep_mode}, 16'h0000);
		$display("bus sleep done");
	endtask
	task automatic t_uv();
		@(posedge clk);
		undervoltage_sleep_allow_in <= 1'h1;
		cell_below_uv <= 1'h1;
		repeat (30) @(negedge clk);
		chk({15'h0, sleep_mode}, 16'h0001);
		@(posedge clk);
		cell_below_uv <= 1'h0;
		undervoltage_sleep_allow_in <= 1'h0;
		host.hold_low(2);
		repeat (3) @(negedge clk);
		chk({15'h0, sleep_mode}, 16'h0000);
		$display("undervoltage sleep done");
	endtask
	// Three updates, so the checked mean holds no sample from before the change
	task automatic t_cur(input logic [11:0] p, input logic [11:0] n, input logic ir,
		input logic [15:0] g, input logic [15:0] exp);
		int i;
		@(posedge clk);
		sense_pos_input <= p;
		sense_neg_input <= n;
		internal_resistor <= ir;
		gain_trim <= g;
		repeat (3) begin
			@(negedge clk);
			for (i = 0; i < 600 && current_update !== 1'h1; i++) @(negedge clk);
		end
		chk({15'h0, current_update}, 16'h0001);
		chk(current_reg, exp);
		$display("current %h done", exp);
	endtask
	initial begin
		internal_resistor <= 1'h0;
		sense_pos_input <= 12'h000;
		sense_neg_input <= 12'h000;
		gain_trim <= 16'h1000;
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		t_defaults();
		t_bus();
		t_uv();
		t_cur(12'h064, 12'h028, 1'h0, 16'h2000, 16'h003C);
		t_cur(12'hED4, 12'h0C8, 1'h0, 16'h1000, 16'hFE0C);
		t_cur(12'h7FF, 12'h800, 1'h0, 16'h1000, 16'h07FF);
		t_cur(12'hC18, 12'h000, 1'h1, 16'h1800, 16'hFA24);
		end_of_test();
	end
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule // gpm_top_bench
bind gpm_top gpm_props #(.SLEEP_DELAY_CYC(SLEEP_DELAY_CYC), .UV_DELAY_CYC(UV_DELAY_CYC)) chk_i (
	.clk, .reset, .bus_line, .sleep_allow_in, .undervoltage_sleep_allow_in, .cell_below_uv,
	.sleep_mode, .measure_enable, .current_reg, .current_update);
